// *** verilog/reset_and_mode_control.sv ***
// Chip reset sequencing, master mode register and output pin test modes
`timescale 1ns/100ps

module reset_and_mode_control #(
    parameter int line_recover_cycles = reset_mode_pkg::line_recover_cycles_dflt
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic hw_chip_reset_pin,
    // Parallel control port
    input wire reset_mode_pkg::host_req_t host_req,
    output reset_mode_pkg::host_rsp_t host_rsp,
    // Chip-wide controls
    output logic chip_reset,
    output logic line_standard_select,
    output logic line_iface_rst,
    output logic line_iface_ready,
    output logic traffic_enable,
    // Output pin control
    input wire logic [7:0] core_pin_out,
    input wire logic [7:0] core_pin_oe_n,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_n,
    output logic port_float
);
    import reset_mode_pkg::*;

    // ----------------------------------------
    // Host access decode
    // ----------------------------------------
    logic wr_stb, rd_stb, wr_q, soft_trig, line_trig;
    logic [7:0] master_mode_q, line_ctrl_q;
    logic [cnt_w-1:0] rst_cnt_q, lir_cnt_q;
    logic chip_reset_q, soft_busy_q, powered_q;
    pin_test_t test_mode;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    function automatic logic is_float(input pin_test_t m);
        is_float = (m == pins_float);
    endfunction : is_float

    assign wr_stb = !host_req.cs_n && !host_req.wr_n && !wr_q;
    assign rd_stb = !host_req.cs_n && !host_req.rd_n;
    assign test_mode = pin_test_t'(master_mode_q[pin_test_hi_bit:pin_test_lo_bit]);

    // Only a 0-to-1 change of a reset bit starts a reset; writes during a chip reset are dropped
    assign soft_trig = wr_stb && !chip_reset_q && hit(host_req.addr, master_mode_offset)
                       && host_req.wdata[soft_chip_reset_bit] && !master_mode_q[soft_chip_reset_bit];
    assign line_trig = wr_stb && hit(host_req.addr, line_iface_ctrl_offset)
                       && host_req.wdata[line_iface_reset_bit] && !line_ctrl_q[line_iface_reset_bit];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_q <= 1'b0;
        end else begin
            wr_q <= !host_req.cs_n && !host_req.wr_n;
        end
    end

    // ----------------------------------------
    // Chip reset sequencer
    // ----------------------------------------
    // Async reset models power-on; it is held in reset for a fixed stretch after release.
    // The hardware pin wins over a soft write landing in the same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rst_cnt_q <= cnt_w'(power_up_cycles);
            chip_reset_q <= 1'b1;
            soft_busy_q <= 1'b0;
            powered_q <= 1'b0;
        end else if (hw_chip_reset_pin) begin
            rst_cnt_q <= cnt_w'(soft_reset_cycles);
            chip_reset_q <= 1'b1;
            soft_busy_q <= 1'b0;
        end else if (soft_trig) begin
            rst_cnt_q <= cnt_w'(soft_reset_cycles);
            chip_reset_q <= 1'b1;
            soft_busy_q <= 1'b1;
        end else if (rst_cnt_q != '0) begin
            rst_cnt_q <= rst_cnt_q - 1'b1;
        end else begin
            chip_reset_q <= 1'b0;
            soft_busy_q <= 1'b0;
            powered_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            master_mode_q <= master_mode_reset;
            line_ctrl_q <= line_iface_ctrl_reset;
        end else if (chip_reset_q && rst_cnt_q != '0) begin
            // Soft reset bit stays set so a poll sees the reset running
            master_mode_q <= soft_busy_q ? (8'h01 << soft_chip_reset_bit) : master_mode_reset;
            line_ctrl_q <= line_iface_ctrl_reset;
        end else if (chip_reset_q) begin
            master_mode_q <= master_mode_reset;
            line_ctrl_q <= line_iface_ctrl_reset;
        end else if (wr_stb && hit(host_req.addr, master_mode_offset)) begin
            // Upper bits are kept at zero regardless of what the host writes
            master_mode_q <= {4'h0, host_req.wdata[3:0]};
        end else if (wr_stb && hit(host_req.addr, line_iface_ctrl_offset)) begin
            line_ctrl_q <= host_req.wdata;
        end
    end

    // ----------------------------------------
    // Line interface reset and recovery
    // ----------------------------------------
    // Recovery length is a parameter so a short run can stand in for the real settling time
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lir_cnt_q <= '0;
            line_iface_rst <= 1'b1;
            line_iface_ready <= 1'b0;
        end else if (chip_reset_q) begin
            lir_cnt_q <= '0;
            line_iface_rst <= 1'b1;
            line_iface_ready <= 1'b0;
        end else if (line_trig) begin
            lir_cnt_q <= cnt_w'(line_recover_cycles);
            line_iface_rst <= 1'b1;
            line_iface_ready <= 1'b0;
        end else if (lir_cnt_q != '0) begin
            lir_cnt_q <= lir_cnt_q - 1'b1;
            line_iface_rst <= 1'b0;
        end else begin
            line_iface_rst <= 1'b0;
            line_iface_ready <= powered_q;
        end
    end

    // ----------------------------------------
    // Mode outputs and pin test forcing
    // ----------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            chip_reset <= 1'b1;
            line_standard_select <= 1'b0;
            traffic_enable <= 1'b0;
            pin_out <= 8'h00;
            pin_oe_n <= 8'hFF;
            port_float <= 1'b0;
        end else begin
            chip_reset <= chip_reset_q;
            line_standard_select <= master_mode_q[line_standard_select_bit];
            traffic_enable <= !chip_reset_q;
            // Float mode also releases the parallel data bus in the read path
            unique case (test_mode)
                pins_normal: begin
                    pin_out <= core_pin_out;
                    pin_oe_n <= core_pin_oe_n;
                    port_float <= 1'b0;
                end
                pins_float: begin
                    pin_out <= 8'h00;
                    pin_oe_n <= 8'hFF;
                    port_float <= 1'b1;
                end
                pins_low: begin
                    pin_out <= 8'h00;
                    pin_oe_n <= 8'h00;
                    port_float <= 1'b0;
                end
                pins_high: begin
                    pin_out <= 8'hFF;
                    pin_oe_n <= 8'h00;
                    port_float <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Unmapped addresses read as zero so a stray poll never sees stale data
    logic [7:0] rdata_d;

    always_comb begin
        rdata_d = 8'h00;
        if (hit(host_req.addr, master_mode_offset)) begin
            rdata_d = master_mode_q;
        end else if (hit(host_req.addr, line_iface_ctrl_offset)) begin
            rdata_d = line_ctrl_q;
        end
    end

    // Registered answer: data follows the strobe by one cycle and drops one cycle after it ends
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            host_rsp <= '{rdata: 8'h00, rdata_oe_n: 1'b1};
        end else begin
            host_rsp.rdata_oe_n <= !(rd_stb && !is_float(test_mode));
            host_rsp.rdata <= rd_stb ? rdata_d : 8'h00;
        end
    end

endmodule : reset_and_mode_control

// *** verilog/reset_mode_pkg.sv ***
// Package: master mode register layout, reset timing and pin-control types
package reset_mode_pkg;

    // ----------------------------------------
    // Register map and field positions
    // ----------------------------------------
    localparam logic [7:0] master_mode_offset = 8'h00;
    localparam logic [7:0] line_iface_ctrl_offset = 8'h79;
    localparam logic [7:0] test_area_offset = 8'hF0;
    localparam logic [7:0] master_mode_reset = 8'h00;
    localparam logic [7:0] line_iface_ctrl_reset = 8'h00;
    localparam int soft_chip_reset_bit = 0;
    localparam int line_standard_select_bit = 1;
    localparam int pin_test_lo_bit = 2;
    localparam int pin_test_hi_bit = 3;
    localparam int line_iface_reset_bit = 6;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int clk_period_ns = 10;
    localparam int soft_reset_ns = 100;
    localparam int soft_reset_cycles = (soft_reset_ns + clk_period_ns - 1) / clk_period_ns;
    localparam int power_up_ns = 200;
    localparam int power_up_cycles = (power_up_ns + clk_period_ns - 1) / clk_period_ns;
    localparam int line_recover_ms = 40;
    localparam int line_recover_cycles_dflt = line_recover_ms * 1000000 / clk_period_ns;
    localparam int cnt_w = 24;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        pins_normal = 2'b00,
        pins_float = 2'b01,
        pins_low = 2'b10,
        pins_high = 2'b11
    } pin_test_t;

    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic [7:0] rdata;
        logic rdata_oe_n;
    } host_rsp_t;

endpackage : reset_mode_pkg

// *** tb/reset_mode_sva.sv ***
// Port assertions for the reset and mode control block
`timescale 1ns/100ps
module reset_mode_sva (
    // Watched ports
    input wire logic clk,
    input wire logic reset,
    input wire logic hw_chip_reset_pin,
    input wire reset_mode_pkg::host_req_t host_req,
    input wire reset_mode_pkg::host_rsp_t host_rsp,
    input wire logic chip_reset,
    input wire logic traffic_enable,
    input wire logic line_iface_rst,
    input wire logic line_iface_ready,
    input wire logic port_float
);
    import reset_mode_pkg::*;
    // ----------------
    // Checks
    // ----------------
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence rd_s;
        !host_req.cs_n && !host_req.rd_n;
    endsequence
    sequence soft_wr_s;
        !host_req.cs_n && !host_req.wr_n && host_req.addr == master_mode_offset && host_req.wdata[0] && !chip_reset;
    endsequence
    hw_reset_a: assert property (hw_chip_reset_pin |-> ##[1:2] chip_reset) else $error("hw reset missed");
    soft_start_a: assert property (soft_wr_s |-> ##[1:3] chip_reset) else $error("soft reset missed");
    soft_done_a: assert property ($rose(chip_reset) |-> ##[1:40] !chip_reset) else $error("reset stuck");
    traffic_off_a: assert property (chip_reset |-> !traffic_enable) else $error("traffic in reset");
    bus_float_a: assert property (port_float |-> host_rsp.rdata_oe_n) else $error("bus driven");
    read_drive_a: assert property (rd_s ##1 !port_float |-> !host_rsp.rdata_oe_n) else $error("no read");
    upper_zero_a: assert property (!host_rsp.rdata_oe_n && $past(host_req.addr) == master_mode_offset
        |-> host_rsp.rdata[7:4] == 4'h0) else $error("upper bits set");
    line_busy_a: assert property (line_iface_rst |-> !line_iface_ready) else $error("ready in reset");
endmodule : reset_mode_sva

bind reset_and_mode_control reset_mode_sva i_reset_mode_sva (
    .clk(clk), .reset(reset), .hw_chip_reset_pin(hw_chip_reset_pin), .host_req(host_req), .host_rsp(host_rsp),
    .chip_reset(chip_reset), .traffic_enable(traffic_enable), .line_iface_rst(line_iface_rst),
    .line_iface_ready(line_iface_ready), .port_float(port_float)
);

// *** tb/host_model.sv ***
// Host processor model for the parallel control port
`timescale 1ns/100ps
module host_model (
    // Control port
    input wire logic clk,
    output reset_mode_pkg::host_req_t req,
    input wire reset_mode_pkg::host_rsp_t rsp
);
    import reset_mode_pkg::*;
    // ----------------
    // Bus cycles
    // ----------------
    initial req = '{1'b1, 1'b1, 1'b1, 8'h00, 8'h00};
    // Released lines show the inverse so stale values cannot pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req = '{1'b0, 1'b1, 1'b0, a, d};
        @(negedge clk);
        req = '{1'b1, 1'b1, 1'b1, ~a, ~d};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [8:0] q);
        @(negedge clk);
        req = '{1'b0, 1'b0, 1'b1, a, ~a};
        @(negedge clk);
        q = {rsp.rdata_oe_n, rsp.rdata};
        req = '{1'b1, 1'b1, 1'b1, ~a, a};
    endtask : rd
endmodule : host_model

// *** tb/testbench.sv ***
// Self-checking bench for the reset and mode control block
`timescale 1ns/100ps
module testbench;
    import reset_mode_pkg::*;
    localparam int lrec = 50;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic hw_chip_reset_pin = 1'b0;
    logic [7:0] core_pin_out = 8'h00;
    logic [7:0] core_pin_oe_n = 8'hFF;
    logic [15:0] rnd = 16'h1381;
    logic [8:0] q;
    logic [7:0] m;
    int n_fail = 0;
    int n_checks = 0;
    int t;
    host_req_t host_req;
    host_rsp_t host_rsp;
    logic chip_reset, line_standard_select, line_iface_rst, line_iface_ready, traffic_enable, port_float;
    logic [7:0] pin_out, pin_oe_n;
    always #5 clk = ~clk;
    host_model h (.clk(clk), .req(host_req), .rsp(host_rsp));
    reset_and_mode_control #(.line_recover_cycles(lrec)) i_reset_and_mode_control (
        .clk(clk), .reset(reset), .hw_chip_reset_pin(hw_chip_reset_pin), .host_req(host_req), .host_rsp(host_rsp),
        .chip_reset(chip_reset), .line_standard_select(line_standard_select), .line_iface_rst(line_iface_rst),
        .line_iface_ready(line_iface_ready), .traffic_enable(traffic_enable), .core_pin_out(core_pin_out),
        .core_pin_oe_n(core_pin_oe_n), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .port_float(port_float));
    // ----------------
    // Helpers
    // ----------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test
    // Waits for reset low (rdy 0) or line ready high (rdy 1)
    task automatic wait_on(input logic rdy);
        t = 0;
        while ((rdy ? line_iface_ready : chip_reset) !== rdy && t < 200) begin
            @(negedge clk);
            t++;
        end
        if (t == 200) begin
            n_fail++;
            stop_test();
        end
    endtask : wait_on
    initial begin
        repeat (2) @(negedge clk);
        reset = 1'b0;
        wait_on(1'b0);
        h.rd(master_mode_offset, q); chk(q, 9'h000);
        h.rd(line_iface_ctrl_offset, q); chk(q, 9'h000);
        // Random unmapped address, kept clear of the factory test area
        rnd = lfsr(rnd);
        h.rd({2'b10, rnd[5:0]}, q); chk(q, 9'h000);
        h.wr(line_iface_ctrl_offset, 8'h40);
        chk(line_iface_rst, 1'b1);
        // Elastic stores live elsewhere; bring-up only waits here until clocks and line have settled
        wait_on(1'b1); chk(t >= lrec - 3 && t <= lrec + 5, 1'b1);
        for (int md = 0; md < 4; md++) begin
            rnd = lfsr(rnd);
            core_pin_out = rnd[7:0];
            core_pin_oe_n = rnd[15:8];
            m = {4'h0, md[1:0], rnd[3], 1'b0};
            h.wr(master_mode_offset, m);
            repeat (2) @(negedge clk);
            chk(line_standard_select, m[1]);
            chk(port_float, md == 1);
            chk(pin_oe_n, md == 1 ? 8'hFF : md == 0 ? rnd[15:8] : 8'h00);
            if (md != 1) chk(pin_out, md[1] ? {8{md[0]}} : rnd[7:0]);
            h.rd(master_mode_offset, q);
            chk(q, {md == 1, m});
            h.wr(line_iface_ctrl_offset, rnd[15:8]);
            h.rd(line_iface_ctrl_offset, q); chk(q, {md == 1, rnd[15:8]});
        end
        h.wr(master_mode_offset, 8'h03);
        h.rd(master_mode_offset, q); chk(q[0], 1'b1);
        chk(traffic_enable, 1'b0);
        wait_on(1'b0);
        chk(traffic_enable, 1'b1);
        h.rd(master_mode_offset, q); chk(q, 9'h000);
        h.rd(line_iface_ctrl_offset, q); chk(q, 9'h000);
        chk(pin_oe_n, core_pin_oe_n);
        h.wr(master_mode_offset, 8'h02);
        h.rd(master_mode_offset, q); chk(q, 9'h002);
        chk(line_standard_select, 1'b1);
        hw_chip_reset_pin = 1'b1;
        @(negedge clk);
        hw_chip_reset_pin = 1'b0;
        repeat (2) @(negedge clk);
        chk(chip_reset, 1'b1);
        wait_on(1'b0);
        h.rd(master_mode_offset, q); chk(q, 9'h000);
        // Second power-on reset in mid-run, with a test mode and E1 selected beforehand
        h.wr(master_mode_offset, 8'h0A);
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        wait_on(1'b0);
        h.rd(master_mode_offset, q); chk(q, 9'h000);
        chk(line_standard_select, 1'b0);
        chk(pin_oe_n, core_pin_oe_n);
        stop_test();
    end
endmodule : testbench
